/* rtl/fbls_core.sv */
// Flag, bit-transfer and load/store execution core with AHB-Lite control
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "fbls_defines.svh"
module fbls_core import fbls_pkg::*; #(
   parameter int SAW  = 16,
   parameter int NREG = 32
) (
   input  wire logic           mclk,
   input  wire logic           rst,
   input  wire logic           hsel,
   input  wire logic [31:0]    haddr,
   input  wire logic [1:0]     htrans,
   input  wire logic           hwrite,
   input  wire logic [2:0]     hsize,
   input  wire logic [31:0]    hwdata,
   input  wire logic           hready,
   output logic                hreadyout,
   output logic                hresp,
   output logic      [31:0]    hrdata,
   output logic      [SAW-1:0] sram_addr,
   output logic      [7:0]     sram_wdata,
   output logic                sram_we,
   output logic                sram_re,
   input  wire logic [7:0]     sram_rdata,
   output logic      [7:0]     flags,
   output logic                busy
);
   localparam int RAW = $clog2(NREG);

   fbls_state_type state_q;
   fbls_state_type state_d;
   logic [15:0]    ir_q;
   logic [15:0]    kword_q;
   logic [7:0]     flags_q;
   logic [RAW-1:0] wsel_q;
   logic [3:0]     cyc_q;
   logic [SAW-1:0] sram_addr_q;
   logic [7:0]     sram_wdata_q;
   logic           sram_we_q;
   logic           sram_re_q;

   logic           wr_en;
   logic [7:0]     wr_addr;
   logic [31:0]    wr_data;
   logic [7:0]     rd_addr;
   logic [31:0]    rd_data;

   logic [3:0]     op;
   logic [2:0]     bit_f;
   logic [1:0]     mode;
   logic           ex1;
   logic           ex2;
   logic           idle;
   logic           go;
   logic           is_mem;
   logic           is_store;
   logic           ptr_upd;
   logic [RAW-2:0] ptr_idx;
   logic [15:0]    ptr_val;
   logic [15:0]    ptr_new;
   logic [15:0]    ea;
   logic [7:0]     rd_val;
   logic [7:0]     sel_val;
   logic [15:0]    src_pair;
   logic           byte_we;
   logic [RAW-1:0] byte_wa;
   logic [7:0]     byte_wd;
   logic           pair_we;
   logic [RAW-2:0] pair_wa;
   logic [15:0]    pair_wd;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] flag_mask(input logic [2:0] pos);
      flag_mask = 8'h01 << pos;
   endfunction

   function automatic logic [3:0] ptr_pair(input logic [1:0] sel);
      case (sel)
         `FBLS_PTR_X: ptr_pair = `FBLS_PAIR_X;
         `FBLS_PTR_Y: ptr_pair = `FBLS_PAIR_Y;
         default:     ptr_pair = `FBLS_PAIR_Z;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   fbls_ahb_slave fbls_ahb_slave_inst (
      .mclk      (mclk),
      .rst       (rst),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .stall     (busy),
      .wr_en     (wr_en),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data),
      .rd_addr   (rd_addr),
      .rd_data   (rd_data)
   );

   fbls_wregs #(
      .NREG (NREG)
   ) fbls_wregs_inst (
      .mclk    (mclk),
      .rst     (rst),
      .byte_we (byte_we),
      .byte_wa (byte_wa),
      .byte_wd (byte_wd),
      .pair_we (pair_we),
      .pair_wa (pair_wa),
      .pair_wd (pair_wd),
      .ra_a    (ir_q[`FBLS_IR_RD]),
      .ra_b    (wsel_q),
      .pa_a    (ptr_idx),
      .pa_b    (ir_q[`FBLS_IR_PR]),
      .rd_a    (rd_val),
      .rd_b    (sel_val),
      .pd_a    (ptr_val),
      .pd_b    (src_pair)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   assign op       = ir_q[`FBLS_IR_OP];
   assign bit_f    = ir_q[`FBLS_IR_BIT];
   assign mode     = ir_q[`FBLS_IR_PMODE];
   assign ex1      = state_q == FBLS_EX1;
   assign ex2      = state_q == FBLS_EX2;
   assign idle     = state_q == FBLS_IDLE;
   assign busy     = !idle;
   assign go       = wr_en && wr_addr == `FBLS_A_CMD;
   assign is_store = op == `FBLS_OP_STI;
   assign is_mem   = op == `FBLS_OP_LDI || op == `FBLS_OP_RDISP || op == `FBLS_OP_RDIRK || is_store;
   assign ptr_upd  = ex1 && (op == `FBLS_OP_LDI || is_store) && mode != `FBLS_MODE_PLAIN;
   assign ptr_idx  = (op == `FBLS_OP_RDISP) ? (ir_q[`FBLS_IR_DSEL] ? `FBLS_PAIR_Z : `FBLS_PAIR_Y)
                                          : ptr_pair(ir_q[`FBLS_IR_PSEL]);
   assign ptr_new  = (mode == `FBLS_MODE_DEC) ? ptr_val - 16'h0001 : ptr_val + 16'h0001;

   always_comb begin
      case (op)
         `FBLS_OP_RDISP: ea = ptr_val + {10'h000, ir_q[`FBLS_IR_DISP]};
         `FBLS_OP_RDIRK: ea = kword_q;
         default:        ea = (mode == `FBLS_MODE_DEC) ? ptr_new : ptr_val;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: one cycle for register ops, two for memory ops
   always_comb begin
      case (state_q)
         FBLS_IDLE: state_d = go ? FBLS_EX1 : FBLS_IDLE;
         FBLS_EX1:  state_d = is_mem ? FBLS_EX2 : FBLS_IDLE;
         FBLS_EX2:  state_d = FBLS_IDLE;
         default:   state_d = FBLS_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= FBLS_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cyc_q <= 4'h0;
      end else if (go) begin
         cyc_q <= `FBLS_CYC_ONE;
      end else if (ex1 && is_mem) begin
         cyc_q <= `FBLS_CYC_TWO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software-visible registers; bus writes only land while idle
   always_ff @(posedge mclk) begin
      if (rst) begin
         ir_q    <= 16'h0000;
         kword_q <= 16'h0000;
         wsel_q  <= '0;
      end else if (wr_en) begin
         case (wr_addr)
            `FBLS_A_CMD:   ir_q    <= wr_data[15:0];
            `FBLS_A_KWORD: kword_q <= wr_data[15:0];
            `FBLS_A_WSEL:  wsel_q  <= wr_data[RAW-1:0];
            default:       ;
         endcase
      end
   end

   always_comb begin
      case (rd_addr)
         `FBLS_A_CMD:   rd_data = {16'h0000, ir_q};
         `FBLS_A_KWORD: rd_data = {16'h0000, kword_q};
         `FBLS_A_FLAGS: rd_data = {24'h000000, flags_q};
         `FBLS_A_STAT:  rd_data = {20'h00000, cyc_q, 7'h00, busy};
         `FBLS_A_WSEL:  rd_data = {{(32-RAW){1'b0}}, wsel_q};
         `FBLS_A_WDATA: rd_data = {24'h000000, sel_val};
         default:       rd_data = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flags register
   always_ff @(posedge mclk) begin
      if (rst) begin
         flags_q <= `FBLS_FLAGS_RST;
      end else if (ex1 && op == `FBLS_OP_FSET) begin
         flags_q <= flags_q | flag_mask(bit_f);
      end else if (ex1 && op == `FBLS_OP_FCLR) begin
         flags_q <= flags_q & ~flag_mask(bit_f);
      end else if (ex1 && op == `FBLS_OP_RBIT2T) begin
         flags_q[`FBLS_F_T] <= rd_val[bit_f];
      end else if (wr_en && wr_addr == `FBLS_A_FLAGS) begin
         flags_q <= wr_data[7:0];
      end
   end
   assign flags = flags_q;

   ////////////////////////////////////////////////////////////////////////////
   // Register file write steering
   always_comb begin
      byte_we = 1'b0;
      byte_wa = ir_q[`FBLS_IR_RD];
      byte_wd = rd_val;
      if (ex1 && op == `FBLS_OP_T2RBIT) begin
         byte_we        = 1'b1;
         byte_wd[bit_f] = flags_q[`FBLS_F_T];
      end else if (ex1 && op == `FBLS_OP_SWAP) begin
         byte_we = 1'b1;
         byte_wd = {rd_val[3:0], rd_val[7:4]};
      end else if (ex2 && !is_store) begin
         byte_we = 1'b1;
         byte_wd = sram_rdata;
      end else if (wr_en && wr_addr == `FBLS_A_WDATA) begin
         byte_we = 1'b1;
         byte_wa = wsel_q;
         byte_wd = wr_data[7:0];
      end
   end

   always_comb begin
      pair_we = 1'b0;
      pair_wa = ptr_idx;
      pair_wd = ptr_new;
      if (ex1 && op == `FBLS_OP_PCOPY) begin
         pair_we = 1'b1;
         pair_wa = ir_q[`FBLS_IR_PD];
         pair_wd = src_pair;
      end else if (ptr_upd) begin
         pair_we = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data SRAM port; address latched on the same edge that moves the pointer
   always_ff @(posedge mclk) begin
      if (rst) begin
         sram_addr_q  <= '0;
         sram_wdata_q <= 8'h00;
      end else if (ex1 && is_mem) begin
         sram_addr_q  <= ea[SAW-1:0];
         sram_wdata_q <= rd_val;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sram_we_q <= 1'b0;
         sram_re_q <= 1'b0;
      end else begin
         sram_we_q <= ex1 && is_store;
         sram_re_q <= ex1 && is_mem && !is_store;
      end
   end

   assign sram_addr  = sram_addr_q;
   assign sram_wdata = sram_wdata_q;
   assign sram_we    = sram_we_q;
   assign sram_re    = sram_re_q;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_load_done;
      idle && rd_val == $past(sram_rdata) && flags_q == $past(flags_q, 2);
   endsequence

   sequence s_store_done;
      idle && !sram_we_q && flags_q == $past(flags_q, 2);
   endsequence

   a_half_set: assert property (ex1 && op == `FBLS_OP_FSET && bit_f == `FBLS_F_H |=>
      idle && flags_q == ($past(flags_q) | flag_mask(`FBLS_F_H))) else $error("half-carry set wrong");
   a_half_clr: assert property (ex1 && op == `FBLS_OP_FCLR && bit_f == `FBLS_F_H |=>
      idle && flags_q == ($past(flags_q) & ~flag_mask(`FBLS_F_H))) else $error("half-carry clear wrong");
   a_ovf_set: assert property (ex1 && op == `FBLS_OP_FSET && bit_f == `FBLS_F_V |=>
      idle && flags_q == ($past(flags_q) | flag_mask(`FBLS_F_V))) else $error("overflow set wrong");
   a_ovf_clr: assert property (ex1 && op == `FBLS_OP_FCLR && bit_f == `FBLS_F_V |=>
      idle && flags_q == ($past(flags_q) & ~flag_mask(`FBLS_F_V))) else $error("overflow clear wrong");
   a_sign_set: assert property (ex1 && op == `FBLS_OP_FSET && bit_f == `FBLS_F_S |=>
      idle && flags_q == ($past(flags_q) | flag_mask(`FBLS_F_S))) else $error("sign set wrong");
   a_sign_clr: assert property (ex1 && op == `FBLS_OP_FCLR && bit_f == `FBLS_F_S |=>
      idle && flags_q == ($past(flags_q) & ~flag_mask(`FBLS_F_S))) else $error("sign clear wrong");
   a_bit_to_t: assert property (ex1 && op == `FBLS_OP_RBIT2T |=> idle &&
      flags_q[`FBLS_F_T] == $past(rd_val[bit_f]) &&
      (flags_q & ~flag_mask(`FBLS_F_T)) == ($past(flags_q) & ~flag_mask(`FBLS_F_T)))
      else $error("bit to T wrong");
   a_t_to_bit: assert property (ex1 && op == `FBLS_OP_T2RBIT |=> idle &&
      rd_val[bit_f] == $past(flags_q[`FBLS_F_T]) && $stable(flags_q)) else $error("T to bit wrong");
   a_rd_postinc: assert property (ex1 && op == `FBLS_OP_LDI && mode == `FBLS_MODE_INC |=>
      ex2 && sram_re_q && sram_addr_q == $past(ptr_val[SAW-1:0]) && ptr_val == $past(ptr_val) + 16'h0001
      ##1 s_load_done) else $error("post-increment read wrong");
   a_rd_predec: assert property (ex1 && op == `FBLS_OP_LDI && mode == `FBLS_MODE_DEC |=>
      ex2 && sram_re_q && ptr_val == $past(ptr_val) - 16'h0001 && sram_addr_q == ptr_val[SAW-1:0]
      ##1 s_load_done) else $error("pre-decrement read wrong");
   a_rd_disp: assert property (ex1 && op == `FBLS_OP_RDISP |=>
      ex2 && sram_re_q && $stable(ptr_val) &&
      sram_addr_q == $past(ea[SAW-1:0]) && $past(ea) == $past(ptr_val) + {10'h000, ir_q[`FBLS_IR_DISP]}
      ##1 s_load_done) else $error("displaced read wrong");
   a_rd_direct: assert property (ex1 && op == `FBLS_OP_RDIRK |=>
      ex2 && sram_re_q && sram_addr_q == $past(kword_q[SAW-1:0]) ##1 s_load_done)
      else $error("direct read wrong");
   a_wr_postinc: assert property (ex1 && is_store && mode == `FBLS_MODE_INC |=>
      ex2 && sram_we_q && sram_wdata_q == $past(rd_val) && sram_addr_q == $past(ptr_val[SAW-1:0]) &&
      ptr_val == $past(ptr_val) + 16'h0001 ##1 s_store_done) else $error("post-increment write wrong");
   a_wr_predec: assert property (ex1 && is_store && mode == `FBLS_MODE_DEC |=>
      ex2 && sram_we_q && sram_wdata_q == $past(rd_val) && ptr_val == $past(ptr_val) - 16'h0001 &&
      sram_addr_q == ptr_val[SAW-1:0] ##1 s_store_done) else $error("pre-decrement write wrong");
   a_nibble_swap: assert property (ex1 && op == `FBLS_OP_SWAP |=> idle && $stable(flags_q) &&
      rd_val == {$past(rd_val[3:0]), $past(rd_val[7:4])}) else $error("nibble swap wrong");
   a_pair_copy: assert property (ex1 && op == `FBLS_OP_PCOPY && !ir_q[7] |=> idle &&
      $stable(flags_q) && rd_val == $past(src_pair[7:0])) else $error("pair copy wrong");
   a_gie_set: assert property (ex1 && op == `FBLS_OP_FSET && bit_f == `FBLS_F_I |=>
      idle && flags_q == ($past(flags_q) | flag_mask(`FBLS_F_I))) else $error("interrupt enable set wrong");
   a_gie_clr: assert property (ex1 && op == `FBLS_OP_FCLR && bit_f == `FBLS_F_I |=>
      idle && flags_q == ($past(flags_q) & ~flag_mask(`FBLS_F_I))) else $error("interrupt enable clear wrong");
endmodule

/* rtl/fbls_defines.svh */
// Constants for the flag, bit and load/store execution block
// Behaviour
// - Flag-set on half-carry forces H high only, one cycle
// - Flag-clear on half-carry forces H low only, one cycle
// - Flag-set on overflow forces V high only, one cycle
// - Flag-clear on overflow forces V low only, one cycle
// - Flag-set on signed flag forces S high only, one cycle
// - Flag-clear on signed flag forces S low only, one cycle
// - Copy bit b of a register into T, only T changes, one cycle
// - Copy T into bit b of a register, flags kept, one cycle
// - Post-increment read: load from pointer, then pointer plus one, two cycles
// - Pre-decrement read: pointer minus one, then load from new address, two cycles
// - Displaced read from Y or Z plus q, pointer kept, two cycles
// - Direct read from address k, two cycles, flags kept
// - Post-increment write to pointer, then pointer plus one, two cycles
// - Pre-decrement write: pointer minus one, then store there, two cycles
`ifndef FBLS_DEFINES_SVH
`define FBLS_DEFINES_SVH
`define FBLS_A_CMD      8'h00
`define FBLS_A_KWORD    8'h04
`define FBLS_A_FLAGS    8'h08
`define FBLS_A_STAT     8'h0c
`define FBLS_A_WSEL     8'h10
`define FBLS_A_WDATA    8'h14
`define FBLS_OP_FSET    4'h0
`define FBLS_OP_FCLR    4'h1
`define FBLS_OP_RBIT2T  4'h2
`define FBLS_OP_T2RBIT  4'h3
`define FBLS_OP_SWAP    4'h4
`define FBLS_OP_PCOPY   4'h5
`define FBLS_OP_LDI     4'h6
`define FBLS_OP_RDISP   4'h7
`define FBLS_OP_RDIRK   4'h8
`define FBLS_OP_STI     4'h9
`define FBLS_IR_OP      15:12
`define FBLS_IR_RD      11:7
`define FBLS_IR_PD      11:8
`define FBLS_IR_PR      6:3
`define FBLS_IR_BIT     2:0
`define FBLS_IR_PSEL    6:5
`define FBLS_IR_PMODE   4:3
`define FBLS_IR_DSEL    6
`define FBLS_IR_DISP    5:0
`define FBLS_F_C        3'h0
`define FBLS_F_Z        3'h1
`define FBLS_F_N        3'h2
`define FBLS_F_V        3'h3
`define FBLS_F_S        3'h4
`define FBLS_F_H        3'h5
`define FBLS_F_T        3'h6
`define FBLS_F_I        3'h7
`define FBLS_PTR_X      2'h0
`define FBLS_PTR_Y      2'h1
`define FBLS_PTR_Z      2'h2
`define FBLS_MODE_PLAIN 2'h0
`define FBLS_MODE_INC   2'h1
`define FBLS_MODE_DEC   2'h2
`define FBLS_PAIR_X     4'hd
`define FBLS_PAIR_Y     4'he
`define FBLS_PAIR_Z     4'hf
`define FBLS_FLAGS_RST  8'h00
`define FBLS_WREG_RST   8'h00
`define FBLS_CYC_ONE    4'h1
`define FBLS_CYC_TWO    4'h2
`endif

/* rtl/fbls_pkg.sv */
// Types shared by the execution block
package fbls_pkg;
   typedef enum logic [2:0] {
      FBLS_IDLE = 3'h1,
      FBLS_EX1  = 3'h2,
      FBLS_EX2  = 3'h4
   } fbls_state_type;
endpackage

/* rtl/fbls_wregs.sv */
// Working register file: byte and pair write ports, combinational reads
`timescale 1ns/1ps
`include "fbls_defines.svh"
module fbls_wregs #(
   parameter int NREG = 32
) (
   input  wire logic                      mclk,
   input  wire logic                      rst,
   input  wire logic                      byte_we,
   input  wire logic [$clog2(NREG)-1:0]   byte_wa,
   input  wire logic [7:0]                byte_wd,
   input  wire logic                      pair_we,
   input  wire logic [$clog2(NREG)-2:0]   pair_wa,
   input  wire logic [15:0]               pair_wd,
   input  wire logic [$clog2(NREG)-1:0]   ra_a,
   input  wire logic [$clog2(NREG)-1:0]   ra_b,
   input  wire logic [$clog2(NREG)-2:0]   pa_a,
   input  wire logic [$clog2(NREG)-2:0]   pa_b,
   output logic      [7:0]                rd_a,
   output logic      [7:0]                rd_b,
   output logic      [15:0]               pd_a,
   output logic      [15:0]               pd_b
);
   localparam int AW = $clog2(NREG);
   logic [7:0] regs_q [NREG];

   ////////////////////////////////////////////////////////////////////////////
   // Byte port wins over pair port when both hit one register
   for (genvar i = 0; i < NREG; i++) begin : g_reg
      always_ff @(posedge mclk) begin
         if (rst) begin
            regs_q[i] <= `FBLS_WREG_RST;
         end else if (byte_we && byte_wa == AW'(i)) begin
            regs_q[i] <= byte_wd;
         end else if (pair_we && pair_wa == (AW-1)'(i / 2)) begin
            regs_q[i] <= (i % 2 == 1) ? pair_wd[15:8] : pair_wd[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign rd_a = regs_q[ra_a];
   assign rd_b = regs_q[ra_b];
   assign pd_a = {regs_q[{pa_a, 1'b1}], regs_q[{pa_a, 1'b0}]};
   assign pd_b = {regs_q[{pa_b, 1'b1}], regs_q[{pa_b, 1'b0}]};
endmodule

/* rtl/fbls_ahb_slave.sv */
// AHB-Lite slave front end: word registers, registered read data
`timescale 1ns/1ps
`include "fbls_defines.svh"
module fbls_ahb_slave (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic        stall,
   output logic             wr_en,
   output logic      [7:0]  wr_addr,
   output logic      [31:0] wr_data,
   output logic      [7:0]  rd_addr,
   input  wire logic [31:0] rd_data
);
   logic       dp_wr_q;
   logic [7:0] dp_addr_q;
   logic       take;

   // Only whole-word transfers are expected; hsize is not checked
   assign take = hsel && htrans[1] && hready;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (rst) begin
         dp_wr_q   <= 1'b0;
         dp_addr_q <= 8'h00;
      end else if (hready) begin
         dp_wr_q   <= take && hwrite;
         dp_addr_q <= haddr[7:0];
      end
   end

   // Read data sampled at the address phase edge
   always_ff @(posedge mclk) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         hrdata <= rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Writes wait while an instruction runs
   assign hreadyout = !(dp_wr_q && stall);
   assign hresp     = 1'b0;
   assign wr_en     = dp_wr_q && !stall;
   assign wr_addr   = dp_addr_q;
   assign wr_data   = hwdata;
   assign rd_addr   = haddr[7:0];
endmodule

/* sim/fbls_sram_model.sv */
// Data SRAM model: asynchronous read, write at the clock edge
`timescale 1ns/1ps
module fbls_sram_model #(
   parameter int SAW = 8
) (
   input  wire logic           mclk,
   input  wire logic [SAW-1:0] addr,
   input  wire logic [7:0]     wdata,
   input  wire logic           we,
   input  wire logic           re,
   output logic      [7:0]     rdata
);
   logic [7:0] mem [0:(1<<SAW)-1];
   logic [7:0] last_q = 8'h00;
   // Plain always: the bench preloads this array directly
   always @(posedge mclk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      if (re) begin
         last_q <= mem[addr];
      end
   end
   // Outside a read the bus shows garbage, so a late sample cannot pass
   assign rdata = re ? mem[addr] : ~last_q;
endmodule

/* sim/flag_bit_and_load_store_exec_tb.sv */
// Self-checking bench for the execution core
`timescale 1ns/1ps
`include "fbls_defines.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; $display("unexpected t=%0t got %h want %h", $time, a, e); end end
module flag_bit_and_load_store_exec_tb;
   logic        mclk = 0, rst = 1, hwrite = 0, hreadyout, hresp, sram_we, sram_re, busy;
   logic [1:0]  htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
   logic [7:0]  sram_addr, sram_wdata, sram_rdata, flags;
   int          fails = 0, total_checks = 0;
   always #2.5 mclk = ~mclk;
   fbls_core #(.SAW(8)) fbls_core_inst (.mclk(mclk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .sram_addr(sram_addr), .sram_wdata(sram_wdata), .sram_we(sram_we), .sram_re(sram_re),
      .sram_rdata(sram_rdata), .flags(flags), .busy(busy));
   fbls_sram_model #(.SAW(8)) fbls_sram_model_inst (.mclk(mclk), .addr(sram_addr), .wdata(sram_wdata),
      .we(sram_we), .re(sram_re), .rdata(sram_rdata));
   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("fails=%0d checks=%0d", fails, total_checks);
      if (fails == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Single word transfer; waits on hready, never on a fixed count
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 50);
      r = hrdata;
      if (n >= 50) begin fails++; close_out; end
   endtask
   task automatic wreg(input logic [4:0] i, input logic [7:0] v);
      ahb(1, `FBLS_A_WSEL, {27'h0, i});
      ahb(1, `FBLS_A_WDATA, {24'h0, v});
   endtask
   task automatic creg(input logic [4:0] i, input logic [7:0] v);
      ahb(1, `FBLS_A_WSEL, {27'h0, i});
      ahb(0, `FBLS_A_WDATA, 32'h0);
      `CHK(r[7:0], v)
   endtask
   task automatic exec(input logic [15:0] i, input logic [3:0] c);
      int n;
      n = 0;
      ahb(1, `FBLS_A_CMD, {16'h0, i});
      do begin ahb(0, `FBLS_A_STAT, 32'h0); n++; end while (r[0] !== 1'b0 && n < 20);
      if (n >= 20) begin fails++; close_out; end
      `CHK(r[11:8], c)
      `CHK({n > 1, busy}, 2'b10)
   endtask
   function automatic logic [15:0] ins(input logic [3:0] o, input logic [4:0] d, input logic [6:0] l);
      return {o, d, l};
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_flags;
      logic [2:0] fl [4] = '{`FBLS_F_H, `FBLS_F_V, `FBLS_F_S, `FBLS_F_I};
      for (int k = 0; k < 4; k++) begin
         ahb(1, `FBLS_A_FLAGS, 32'h0);
         exec(ins(`FBLS_OP_FSET, 5'h0, {4'h0, fl[k]}), `FBLS_CYC_ONE);
         `CHK(flags, 8'h01 << fl[k])
         ahb(1, `FBLS_A_FLAGS, 32'hff);
         exec(ins(`FBLS_OP_FCLR, 5'h0, {4'h0, fl[k]}), `FBLS_CYC_ONE);
         `CHK(flags, ~(8'h01 << fl[k]))
      end
   endtask
   task automatic t_bits;
      wreg(5'd3, 8'ha5);
      ahb(1, `FBLS_A_FLAGS, 32'h0);
      exec(ins(`FBLS_OP_RBIT2T, 5'd3, 7'h0), `FBLS_CYC_ONE);
      `CHK(flags, 8'h40)
      exec(ins(`FBLS_OP_T2RBIT, 5'd4, 7'h6), `FBLS_CYC_ONE);
      creg(5'd4, 8'h40);
      `CHK(flags, 8'h40)
      exec(ins(`FBLS_OP_RBIT2T, 5'd3, 7'h1), `FBLS_CYC_ONE);
      `CHK(flags, 8'h00)
      exec(ins(`FBLS_OP_SWAP, 5'd3, 7'h0), `FBLS_CYC_ONE);
      creg(5'd3, 8'h5a);
      wreg(5'd2, 8'h11);
      exec(ins(`FBLS_OP_PCOPY, 5'h4, 7'h08), `FBLS_CYC_ONE);
      creg(5'd4, 8'h11);
      creg(5'd5, 8'h5a);
   endtask
   task automatic t_loads;
      fbls_sram_model_inst.mem[8'h10] = 8'h3c;
      fbls_sram_model_inst.mem[8'h11] = 8'h55;
      fbls_sram_model_inst.mem[8'h25] = 8'hc3;
      fbls_sram_model_inst.mem[8'h30] = 8'h99;
      ahb(1, `FBLS_A_FLAGS, 32'h2a);
      wreg(5'd26, 8'h10);
      exec(ins(`FBLS_OP_LDI, 5'd1, {`FBLS_PTR_X, `FBLS_MODE_INC, 3'h0}), `FBLS_CYC_TWO);
      creg(5'd1, 8'h3c);
      creg(5'd26, 8'h11);
      exec(ins(`FBLS_OP_LDI, 5'd2, {`FBLS_PTR_X, `FBLS_MODE_DEC, 3'h0}), `FBLS_CYC_TWO);
      creg(5'd26, 8'h10);
      creg(5'd2, 8'h3c);
      wreg(5'd28, 8'h20);
      exec(ins(`FBLS_OP_RDISP, 5'd6, {1'b0, 6'h05}), `FBLS_CYC_TWO);
      creg(5'd6, 8'hc3);
      creg(5'd28, 8'h20);
      ahb(1, `FBLS_A_KWORD, 32'h30);
      exec(ins(`FBLS_OP_RDIRK, 5'd7, 7'h0), `FBLS_CYC_TWO);
      creg(5'd7, 8'h99);
      // Z pointer, plain mode, then Z plus displacement
      wreg(5'd30, 8'h11);
      exec(ins(`FBLS_OP_LDI, 5'd9, {`FBLS_PTR_Z, `FBLS_MODE_PLAIN, 3'h0}), `FBLS_CYC_TWO);
      creg(5'd9, 8'h55);
      creg(5'd30, 8'h11);
      exec(ins(`FBLS_OP_RDISP, 5'd10, {1'b1, 6'h14}), `FBLS_CYC_TWO);
      creg(5'd10, 8'hc3);
      creg(5'd30, 8'h11);
      `CHK(flags, 8'h2a)
   endtask
   // Second command is issued while the first still runs: its data phase stalls
   task automatic t_stores;
      wreg(5'd28, 8'h40);
      wreg(5'd8, 8'he1);
      wreg(5'd9, 8'h1e);
      ahb(1, `FBLS_A_CMD, {16'h0, ins(`FBLS_OP_STI, 5'd8, {`FBLS_PTR_Y, `FBLS_MODE_INC, 3'h0})});
      exec(ins(`FBLS_OP_STI, 5'd9, {`FBLS_PTR_X, `FBLS_MODE_DEC, 3'h0}), `FBLS_CYC_TWO);
      `CHK(fbls_sram_model_inst.mem[8'h40], 8'he1)
      creg(5'd28, 8'h41);
      creg(5'd26, 8'h0f);
      `CHK(fbls_sram_model_inst.mem[8'h0f], 8'h1e)
      `CHK(flags, 8'h2a)
      `CHK(hresp, 1'b0)
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      `CHK(flags, 8'h00)
      t_flags;
      t_bits;
      t_loads;
      t_stores;
      close_out;
   end
endmodule
